//--- include/temp_scan_pkg.sv
// Package of offsets, fields, reset values and timing for the temperature scan readout
package temp_scan_pkg;

   // APB byte addresses (printed offsets are not all multiples of four: index * 4)
   localparam logic [7:0]  IDX_CAPABILITY     = 8'h08;          // Capabilities index
   localparam logic [7:0]  IDX_READOUT        = 8'h09;          // Readout index
   localparam logic [7:0]  IDX_TEMP_CONTROL   = 8'h0A;          // Temperature control index
   localparam logic [7:0]  IDX_FUNC_STATUS    = 8'h04;          // Status index
   localparam logic [7:0]  IDX_DEVICE_CONTROL = 8'h05;          // Device control index
   localparam logic [7:0]  IDX_SCAN_DIVIDER   = 8'h10;          // Scan period index
   localparam logic [9:0]  ADDR_CAPABILITY    = {IDX_CAPABILITY, 2'b00};
   localparam logic [9:0]  ADDR_READOUT       = {IDX_READOUT, 2'b00};
   localparam logic [9:0]  ADDR_TEMP_CONTROL  = {IDX_TEMP_CONTROL, 2'b00};
   localparam logic [9:0]  ADDR_FUNC_STATUS   = {IDX_FUNC_STATUS, 2'b00};
   localparam logic [9:0]  ADDR_DEVICE_CONTROL = {IDX_DEVICE_CONTROL, 2'b00};
   localparam logic [9:0]  ADDR_SCAN_DIVIDER  = {IDX_SCAN_DIVIDER, 2'b00};

   // Capabilities fields
   localparam logic [2:0]  CAP_RESOLUTION     = 3'h1;           // 0.5 C per lsb
   localparam logic [2:0]  CAP_NUM_BITS       = 3'h1;           // Ten significant bits
   localparam logic        CAP_SIGNED         = 1'b1;           // Two's complement
   localparam logic        CAP_READOUT_WIDTH  = 1'b0;           // 16-bit readout
   localparam logic        CAP_INTERNAL       = 1'b1;           // Local sensor present
   localparam logic [2:0]  CAP_REMOTE_COUNT   = 3'h2;           // Two remote diodes
   localparam logic [15:0] CAP_RESET          = 16'h0549;       // Expected value

   // Readout field positions
   localparam int          RD_TEMP_LSB        = 6;              // Temperature bits 15-6
   localparam int          RD_INDEX_LSB       = 2;              // Index bits 3-2
   localparam int          RD_ERROR_BIT       = 1;              // Remote error bit
   // Temperature control bit positions
   localparam int          CTL_ATTN_BIT       = 0;
   localparam int          CTL_EN_LSB         = 1;              // Enables bits 3-1
   // Status bit positions
   localparam int          ST_EVENT_BIT       = 0;
   localparam int          ST_OVERRUN_BIT     = 4;
   // Device control bit positions
   localparam int          DC_LOWPWR_BIT      = 2;
   localparam int          DC_ENABLE_BIT      = 4;

   // Reset values
   localparam logic [3:0]  TEMP_CONTROL_RESET = 4'h0;
   localparam logic [31:0] SCAN_DIVIDER_RESET = 32'h0000_03E8;  // Cycles per conversion slot
   localparam int          LOWPWR_FACTOR      = 4;              // Low power slows by four

   // Scan state
   typedef enum logic [1:0] {
      SCAN_IDLE = 2'b00,
      SCAN_CONV = 2'b01
   } scan_state_t;

endpackage

//--- rtl/temp_scan_readout.sv
// Temperature scan readout: sensor round robin, readout register, flags and APB slave
// Contract
// - Scan enabled sensors continuously while enabled
// - Scan only sensors whose enable is set
// - Ascending index order, skip disabled, wrap
// - Low power scans four times slower
// - New result sets sticky event flag
// - Readout read clears event and overrun
// - Unread overwrite sets overrun flag
// - Readout holds temperature and index 0-2
// - Index 0 is local junction sensor
// - Attention only when attention enable set
// - Resolution fixed, writes cannot change it
// - One signed fixed point encoding
// - Works without configuration before enable; sensor enables reset to 0, so nothing scans until one is written
// - Capabilities at 08h reading 0549h
// - Capabilities bits 2-0 read 001
// - Capabilities bits 5-3 read 001
// - Capabilities bit 6 reads 1
// - Capabilities bit 7 reads 0
// - Capabilities bit 8 reads 1
// - Capabilities bits 11-9 read two
// - Capabilities bits 15-12 read zero
// - Readout layout: temp 15-6, index 3-2, error 1
// - Event bit 0, overrun bit 4 of status
// - Attention needs a sensor enable too
`timescale 1ns/1ns
`default_nettype none

module temp_scan_readout (
   // Clock and reset
   input  wire logic        REF_CLK_IN,
   input  wire logic        RST_B_IN,
   // APB slave
   input  wire logic        PSEL_IN,
   input  wire logic        PENABLE_IN,
   input  wire logic        PWRITE_IN,
   input  wire logic [11:0] PADDR_IN,
   input  wire logic [31:0] PWDATA_IN,
   output logic [31:0]      PRDATA_OUT,
   output logic             PREADY_OUT,
   output logic             PSLVERR_OUT,
   // Converter: request and result
   output logic             CONV_START_OUT,
   output logic [1:0]       CONV_INDEX_OUT,
   input  wire logic        CONV_DONE_IN,
   input  wire logic [9:0]  CONV_TEMP_IN,
   input  wire logic        CONV_FAULT_IN,
   // Function state to device logic
   output logic             FUNCTION_EVENT_OUT,
   output logic             FUNCTION_ERROR_OUT,
   output logic             ATTENTION_REQUEST_OUT
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   logic [3:0]               temp_control;        // Enables and attention enable
   logic                     function_enable;     // Device control enable
   logic                     low_power;           // Device control low power
   logic [31:0]              scan_divider;        // Active cycles per slot
   logic [31:0]              slot_count;          // Slot timer
   logic [1:0]               sensor_index;        // Sensor being converted
   logic [1:0]               next_index;          // Next enabled sensor
   temp_scan_pkg::scan_state_t scan_state;        // Scan state
   logic [31:0]              start_gap;           // Cycles since the last start
   logic [15:0]              readout;             // Readout register
   logic                     readout_unread;      // Result not yet read
   logic                     function_event_flag;
   logic                     function_overrun_flag;
   logic                     any_enable;
   logic                     slot_tick;
   logic                     apb_access;
   logic                     apb_wr;
   logic                     readout_read;
   logic                     result_store;
   logic [31:0]              slot_limit;
   logic [15:0]              capability;
   logic                     local_zone_enable;
   logic                     remote_zone1_enable;
   logic                     remote_zone2_enable;
   logic                     attention_request_enable;

   assign attention_request_enable = temp_control[package_attn()];
   assign local_zone_enable        = temp_control[1];
   assign remote_zone1_enable      = temp_control[2];
   assign remote_zone2_enable      = temp_control[3];
   assign any_enable = local_zone_enable | remote_zone1_enable | remote_zone2_enable;

   // Position helper kept as a function so the bit index has one definition
   function automatic int package_attn();
      return temp_scan_pkg::CTL_ATTN_BIT;
   endfunction

   // Next enabled index strictly above the current one, wrapping
   function automatic logic [1:0] next_enabled(input logic [1:0] cur, input logic [2:0] en);
      logic [1:0] cand;
      logic [1:0] pick;
      cand = cur;
      pick = cur;
      for (int k = 0; k < 3; k++) begin
         cand = (cand == 2'd2) ? 2'd0 : 2'(cand + 2'd1);
         if (en[cand] && pick == cur) begin
            pick = cand;
         end
      end
      // Only the current sensor enabled: stay on it
      return en[pick] ? pick : cur;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Capabilities value built from fields; constant, no write path

   assign capability = {4'h0,
                        temp_scan_pkg::CAP_REMOTE_COUNT,
                        temp_scan_pkg::CAP_INTERNAL,
                        temp_scan_pkg::CAP_READOUT_WIDTH,
                        temp_scan_pkg::CAP_SIGNED,
                        temp_scan_pkg::CAP_NUM_BITS,
                        temp_scan_pkg::CAP_RESOLUTION};

   ////////////////////////////////////////////////////////////////////////////
   // APB decode: zero wait states, unmapped addresses answer with an error

   assign apb_access   = PSEL_IN & PENABLE_IN;
   assign apb_wr       = apb_access & PWRITE_IN;
   assign readout_read = apb_access & ~PWRITE_IN
                         & (PADDR_IN[9:0] == temp_scan_pkg::ADDR_READOUT)
                         & (PADDR_IN[11:10] == 2'b00);
   assign PREADY_OUT   = 1'b1;

   // Error answer for anything outside the map
   always_comb begin
      PSLVERR_OUT = 1'b0;
      if (apb_access) begin
         if (PADDR_IN[11:10] != 2'b00) begin
            PSLVERR_OUT = 1'b1;
         end else begin
            unique case (PADDR_IN[9:0])
               temp_scan_pkg::ADDR_CAPABILITY,
               temp_scan_pkg::ADDR_READOUT,
               temp_scan_pkg::ADDR_TEMP_CONTROL,
               temp_scan_pkg::ADDR_FUNC_STATUS,
               temp_scan_pkg::ADDR_DEVICE_CONTROL,
               temp_scan_pkg::ADDR_SCAN_DIVIDER: PSLVERR_OUT = 1'b0;
               default:                          PSLVERR_OUT = 1'b1;
            endcase
         end
      end
   end

   // Read data registered? No: combinational mux, valid in the access cycle
   always_comb begin
      PRDATA_OUT = 32'h0000_0000;
      if (apb_access && !PWRITE_IN && PADDR_IN[11:10] == 2'b00) begin
         unique case (PADDR_IN[9:0])
            temp_scan_pkg::ADDR_CAPABILITY:   PRDATA_OUT = {16'h0000, capability};
            temp_scan_pkg::ADDR_READOUT:      PRDATA_OUT = {16'h0000, readout};
            temp_scan_pkg::ADDR_TEMP_CONTROL: PRDATA_OUT = {28'h000_0000, temp_control};
            temp_scan_pkg::ADDR_FUNC_STATUS: begin
               PRDATA_OUT[temp_scan_pkg::ST_EVENT_BIT]   = function_event_flag;
               PRDATA_OUT[temp_scan_pkg::ST_OVERRUN_BIT] = function_overrun_flag;
            end
            temp_scan_pkg::ADDR_DEVICE_CONTROL: begin
               PRDATA_OUT[temp_scan_pkg::DC_LOWPWR_BIT] = low_power;
               PRDATA_OUT[temp_scan_pkg::DC_ENABLE_BIT] = function_enable;
            end
            temp_scan_pkg::ADDR_SCAN_DIVIDER: PRDATA_OUT = scan_divider;
            default:                          PRDATA_OUT = 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control registers; capabilities has no write path at all

   always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         temp_control    <= temp_scan_pkg::TEMP_CONTROL_RESET;
         function_enable <= 1'b0;
         low_power       <= 1'b0;
         scan_divider    <= temp_scan_pkg::SCAN_DIVIDER_RESET;
      end else if (apb_wr && PADDR_IN[11:10] == 2'b00) begin
         // Resolution fields are constants, writes never reach them
         if (PADDR_IN[9:0] == temp_scan_pkg::ADDR_TEMP_CONTROL) begin
            temp_control <= PWDATA_IN[3:0];
         end
         if (PADDR_IN[9:0] == temp_scan_pkg::ADDR_DEVICE_CONTROL) begin
            low_power       <= PWDATA_IN[temp_scan_pkg::DC_LOWPWR_BIT];
            function_enable <= PWDATA_IN[temp_scan_pkg::DC_ENABLE_BIT];
         end
         // Zero would stall the timer forever, so it is kept at least one
         if (PADDR_IN[9:0] == temp_scan_pkg::ADDR_SCAN_DIVIDER) begin
            scan_divider <= (PWDATA_IN == 32'h0000_0000) ? 32'h0000_0001 : PWDATA_IN;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Slot timer: one conversion started per slot, four times longer in low power

   assign slot_limit = low_power ? 32'(scan_divider * temp_scan_pkg::LOWPWR_FACTOR)
                                 : scan_divider;
   assign slot_tick  = (slot_count >= slot_limit - 32'h0000_0001);

   always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         slot_count <= 32'h0000_0000;
      end else if (!function_enable || !any_enable || slot_tick) begin
         slot_count <= 32'h0000_0000;
      end else begin
         slot_count <= slot_count + 32'h0000_0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Scan sequencer

   assign next_index     = next_enabled(sensor_index, temp_control[3:1]);
   assign CONV_START_OUT = (scan_state == temp_scan_pkg::SCAN_IDLE) & function_enable
                           & any_enable & slot_tick;
   assign CONV_INDEX_OUT = sensor_index;

   always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         scan_state   <= temp_scan_pkg::SCAN_IDLE;
         sensor_index <= 2'd2;   // First advance lands on the lowest enabled index
      end else begin
         unique case (scan_state)
            temp_scan_pkg::SCAN_IDLE: begin
               // Index chosen at start so a disabled sensor is never requested
               if (CONV_START_OUT) begin
                  sensor_index <= next_index;
                  scan_state   <= temp_scan_pkg::SCAN_CONV;
               end
            end
            temp_scan_pkg::SCAN_CONV: begin
               // Clearing the function enable or every sensor enable mid conversion drops the result
               if (!function_enable || !any_enable) begin
                  scan_state <= temp_scan_pkg::SCAN_IDLE;
               end else if (CONV_DONE_IN) begin
                  scan_state <= temp_scan_pkg::SCAN_IDLE;
               end
            end
            default: scan_state <= temp_scan_pkg::SCAN_IDLE;
         endcase
      end
   end

   // Cycles since the last start; saturates so a long idle never wraps short
   // Read only by the slot assertions below
   always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         start_gap <= 32'h0000_0000;
      end else if (CONV_START_OUT) begin
         start_gap <= 32'h0000_0001;
      end else if (start_gap != 32'hFFFF_FFFF) begin
         start_gap <= start_gap + 32'h0000_0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Readout register and flags

   assign result_store = (scan_state == temp_scan_pkg::SCAN_CONV) & CONV_DONE_IN
                         & function_enable & any_enable;

   always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         readout <= 16'h0000;
      end else if (result_store) begin
         // Signed 10-bit temperature, index, remote fault; local has no fault bit
         readout <= {CONV_TEMP_IN, 2'b00, sensor_index,
                     (sensor_index != 2'd0) & CONV_FAULT_IN, 1'b0};
      end
   end

   // Event and overrun: a store in the same cycle as a clearing read keeps event set but clears overrun
   always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         function_event_flag   <= 1'b0;
         function_overrun_flag <= 1'b0;
         readout_unread        <= 1'b0;
      end else if (result_store) begin
         function_event_flag <= 1'b1;
         readout_unread      <= 1'b1;
         // Overrun only if the old one is still unread and not being read now
         if (readout_unread && !readout_read) begin
            function_overrun_flag <= 1'b1;
         end else if (readout_read) begin
            function_overrun_flag <= 1'b0;
         end
      end else if (readout_read) begin
         function_event_flag   <= 1'b0;
         function_overrun_flag <= 1'b0;
         readout_unread        <= 1'b0;
      end
   end

   assign FUNCTION_EVENT_OUT    = function_event_flag;
   assign FUNCTION_ERROR_OUT    = function_overrun_flag;
   assign ATTENTION_REQUEST_OUT = function_event_flag & attention_request_enable
                                  & any_enable;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   sequence store_s;
      result_store;
   endsequence

   sequence flag_up_s;
      function_event_flag;
   endsequence

   AST_EVENT_SET: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      store_s |=> flag_up_s)
      else $error("event flag not set after result");

   AST_READ_CLEARS: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (readout_read && !result_store) |=> !function_event_flag && !function_overrun_flag)
      else $error("readout read did not clear flags");

   AST_OVERRUN: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (result_store && readout_unread && !readout_read) |=> function_overrun_flag)
      else $error("overrun not flagged");

   AST_NO_ENABLE: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      !any_enable |-> !CONV_START_OUT && !result_store)
      else $error("conversion with no sensor enabled");

   AST_INDEX_ENABLED: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      CONV_START_OUT |-> temp_control[ctl_en_idx(next_index)])
      else $error("disabled sensor scanned");

   AST_INDEX_RANGE: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      readout[3:2] != 2'd3)
      else $error("readout index out of range");

   AST_CAPABILITY: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      capability == temp_scan_pkg::CAP_RESET)
      else $error("capabilities value wrong");

   AST_ATTENTION: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      ATTENTION_REQUEST_OUT |-> attention_request_enable && function_event_flag
                                && $past(function_event_flag) | $past(result_store))
      else $error("attention without enable");

   AST_LOWPWR_SLOT: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (low_power && CONV_START_OUT)
      |-> start_gap >= 32'(scan_divider * temp_scan_pkg::LOWPWR_FACTOR))
      else $error("low power slot too short");

   AST_ACTIVE_SLOT: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (!low_power && CONV_START_OUT) |-> start_gap >= scan_divider)
      else $error("active slot too short");

   AST_READOUT_HELD: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      !result_store |=> $stable(readout))
      else $error("readout changed without a result");

   AST_ATTN_SENSOR: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      ATTENTION_REQUEST_OUT |-> any_enable)
      else $error("attention with no sensor enabled");

   // Enable bit for a sensor index inside the control register
   function automatic int ctl_en_idx(input logic [1:0] idx);
      return temp_scan_pkg::CTL_EN_LSB + int'(idx);
   endfunction

endmodule

`default_nettype wire

//--- verif/conv_model.sv
// Behavioural converter that answers each start request with one result pulse
`timescale 1ns/1ns
`default_nettype none

module conv_model #(
   parameter int LAT = 3                    // Cycles from known index to result
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_b,
   // Request from the readout block
   input  wire logic       start,
   input  wire logic [1:0] index,
   input  wire logic [2:0] fault_mask,      // Zones that report a diode fault
   // Result back to the readout block
   output logic            done,
   output logic [9:0]      temp,
   output logic            fault
);
   logic [9:0] tbl [3];                     // Fixed result per zone
   logic       armed;                       // Start seen, index lands now
   logic [1:0] zone;                        // Zone under conversion
   int         cnt;                         // Cycles left to the result

   initial begin
      tbl = '{10'h0C8, 10'h3B0, 10'h201};
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Result after LAT cycles; lines are not held between results, so they toggle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         armed <= 1'b0;
         zone  <= 2'h0;
         cnt   <= 0;
         done  <= 1'b0;
         temp  <= 10'h000;
         fault <= 1'b0;
      end else begin
         armed <= start;
         done  <= 1'b0;
         temp  <= ~temp;                    // Stale value never looks valid
         fault <= ~fault;
         if (armed) begin                   // Index is updated one cycle after start
            zone <= index;
            cnt  <= LAT;
         end else if (cnt != 0) begin
            cnt <= cnt - 1;
            if (cnt == 1) begin             // One-cycle result pulse
               done  <= 1'b1;
               temp  <= tbl[zone];
               fault <= fault_mask[zone];
            end
         end
      end
   end
endmodule

`default_nettype wire

//--- verif/temp_scan_readout_tb.sv
// Self-checking bench for the temperature scan readout
`timescale 1ns/1ns
`default_nettype none

module temp_scan_readout_tb;
   localparam logic [31:0] DIV = 32'h0000_0010;  // Short slot keeps the run brief
   localparam int          LAT = 3;              // Converter answer delay
   logic        clk, rst_b, psel, penable, pwrite, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, start, done, fault, event_f, err_f, attn;
   logic [1:0]  index, idx, prv;
   logic [9:0]  temp;
   logic [3:0]  cfg [3];
   int          err_total, compares, starts, gap, snap;

   temp_scan_readout uut (
      .REF_CLK_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel), .PENABLE_IN(penable),
      .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
      .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .CONV_START_OUT(start),
      .CONV_INDEX_OUT(index), .CONV_DONE_IN(done), .CONV_TEMP_IN(temp),
      .CONV_FAULT_IN(fault), .FUNCTION_EVENT_OUT(event_f),
      .FUNCTION_ERROR_OUT(err_f), .ATTENTION_REQUEST_OUT(attn));

   conv_model #(.LAT(LAT)) partner (
      .clk(clk), .rst_b(rst_b), .start(start), .index(index),
      .fault_mask(3'b101), .done(done), .temp(temp), .fault(fault));

   ////////////////////////////////////////////////////////////////////////////////
   // Clock and start counter
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) if (start === 1'b1) starts <= starts + 1;

   // Expected readout word for a zone; local fault is never reported
   function automatic logic [31:0] exp_rd(input logic [1:0] i);
      logic [9:0] t;
      t = (i == 2'h0) ? 10'h0C8 : (i == 2'h1) ? 10'h3B0 : 10'h201;
      return {16'h0000, t, 2'b00, i, (i == 2'h2), 1'b0};
   endfunction

   // Next enabled zone above p, wrapping
   function automatic logic [1:0] nxt(input logic [1:0] p, input logic [2:0] en);
      logic [1:0] c;
      c = p;
      for (int k = 0; k < 3; k++) begin
         c = (c == 2'h2) ? 2'h0 : c + 2'h1;
         if (en[c]) return c;
      end
      return p;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Verdict, comparison and bus tasks
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t %s: saw %h expected %h", $time, m, seen, exp);
      end
   endtask

   task automatic hang(input string m);
      check(32'h0, 32'h1, m);
      report_and_stop();
   endtask

   // One APB transfer; request held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] wd);
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= {2'b00, a};
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      for (int k = 0; k < 20; k++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (pready !== 1'b1) hang("bus answer missing");
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input logic [9:0] a, input logic [31:0] exp, input string m);
      apb(1'b0, a, 32'h0);
      check(rd, exp, m);
   endtask

   // Waits for a start pulse; returns edges since the previous one and the zone
   task automatic wait_start(output int cyc);
      cyc = 1;
      while (start !== 1'b1) begin
         @(posedge clk);
         cyc++;
         if (cyc > 6000) hang("no conversion start");
      end
      @(posedge clk);
      idx = index;
   endtask

   task automatic wait_event;
      for (int k = 0; k < 100 && event_f !== 1'b1; k++) @(posedge clk);
      if (event_f !== 1'b1) hang("no function event");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h000; pwdata = 32'h0; cfg = '{4'hA, 4'h4, 4'hE};
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      // Capabilities word, read-only, and an unmapped place
      rdchk(temp_scan_pkg::ADDR_CAPABILITY, 32'h0000_0549, "caps");
      apb(1'b1, temp_scan_pkg::ADDR_CAPABILITY, 32'hFFFF_FFF8);
      rdchk(temp_scan_pkg::ADDR_CAPABILITY, 32'h0000_0549, "caps after write");
      apb(1'b0, 10'h3FC, 32'h0);
      check({31'h0, er}, 32'h1, "unmapped error");
      rdchk(temp_scan_pkg::ADDR_FUNC_STATUS, 32'h0, "status at reset");
      // Enabled function but no sensors: nothing happens
      apb(1'b1, temp_scan_pkg::ADDR_DEVICE_CONTROL, 32'h0000_0010);
      repeat (200) @(posedge clk);
      check(starts, 0, "start with no sensor");
      // Default settings, local zone only
      apb(1'b1, temp_scan_pkg::ADDR_TEMP_CONTROL, 32'h0000_0002);
      wait_start(gap);
      check({30'h0, idx}, 32'h0, "local zone index");
      wait_event();
      rdchk(temp_scan_pkg::ADDR_READOUT, exp_rd(2'h0), "local readout");
      @(posedge clk);
      check({30'h0, err_f, event_f}, 32'h0, "flags after read");
      // Fast slot, far above the minimum refresh rate
      apb(1'b1, temp_scan_pkg::ADDR_SCAN_DIVIDER, DIV);
      foreach (cfg[c]) begin
         apb(1'b1, temp_scan_pkg::ADDR_TEMP_CONTROL, {28'h0, cfg[c]});
         wait_start(gap);
         prv = idx;
         repeat (4) begin
            wait_start(gap);
            check({30'h0, idx}, {30'h0, nxt(prv, cfg[c][3:1])}, "scan order");
            prv = idx;
         end
      end
      // Two results without a read: overrun, newest result kept
      apb(1'b0, temp_scan_pkg::ADDR_READOUT, 32'h0);
      wait_start(gap);
      wait_start(gap);
      repeat (LAT + 3) @(posedge clk);
      check({31'h0, err_f}, 32'h1, "overrun flag");
      rdchk(temp_scan_pkg::ADDR_FUNC_STATUS, 32'h0000_0011, "status flags");
      rdchk(temp_scan_pkg::ADDR_READOUT, exp_rd(idx), "overwritten readout");
      @(posedge clk);
      check({30'h0, err_f, event_f}, 32'h0, "flags cleared");
      // Attention follows its enable and needs a sensor enable
      wait_event();
      check({31'h0, attn}, 32'h0, "attention disabled");
      apb(1'b1, temp_scan_pkg::ADDR_TEMP_CONTROL, 32'h0000_000F);
      @(posedge clk);
      check({31'h0, attn}, 32'h1, "attention enabled");
      apb(1'b1, temp_scan_pkg::ADDR_TEMP_CONTROL, 32'h0000_0001);
      @(posedge clk);
      check({31'h0, attn}, 32'h0, "attention without sensor");
      snap = starts;
      repeat (100) @(posedge clk);
      check(starts, snap, "scan stopped");
      // Slot length in active and low-power mode
      apb(1'b1, temp_scan_pkg::ADDR_TEMP_CONTROL, 32'h0000_0002);
      repeat (3) wait_start(gap);
      check({31'h0, gap >= DIV && gap <= DIV + LAT + 8}, 32'h1, "active slot");
      apb(1'b1, temp_scan_pkg::ADDR_DEVICE_CONTROL, 32'h0000_0014);
      repeat (3) wait_start(gap);
      check({31'h0, gap >= 4 * DIV && gap <= 4 * DIV + LAT + 8}, 32'h1, "low power slot");
      report_and_stop();
   end
endmodule

`default_nettype wire
